// File: core/pwm_consts.svh
// Register offsets, field positions, reset values and timing counts of the standard PWM channel.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define OFS_CHANNEL_CONTROL   6'h00
`define OFS_DUTY_LOW_BUFFER   6'h04
`define OFS_DUTY_ACTIVE_COPY  6'h08
`define OFS_PERIOD_LIMIT      6'h0C
`define OFS_PERIOD_TIMER_CTRL 6'h10
`define OFS_TIMER_SELECT      6'h14
`define OFS_PIN_DIRECTION     6'h18
`define OFS_INTERRUPT_REQUEST 6'h1C
`define OFS_PERIOD_TIMER_CNT  6'h20
`define OFS_CHANNEL_STATUS    6'h24

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CTRL_MODE_LSB         0
`define CTRL_MODE_MSB         3
`define CTRL_FRAC_LSB         4
`define CTRL_FRAC_MSB         5
`define TCTRL_PSC_LSB         0
`define TCTRL_PSC_MSB         1
`define TCTRL_RUN_BIT         2
`define TCTRL_POST_LSB        3
`define TCTRL_POST_MSB        6
`define PWM_MODE_CODE         2'b11

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define RST_CHANNEL_CONTROL   8'h00
`define RST_DUTY              8'h00
`define RST_PERIOD_LIMIT      8'hFF
`define RST_TIMER_CTRL        8'h00
`define RST_TIMER_SELECT      2'b00
`define RST_PIN_DIRECTION     1'b1

// ---------------------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------------------
`define OSC_PER_INSTR         4
`define PSC_DIV_1             1
`define PSC_DIV_4             4
`define PSC_DIV_16            16

`endif

// File: core/pwm_pkg.sv
// Types shared by the standard PWM channel.
package pwm_pkg;

  typedef enum logic [1:0] {
    PSC_1_TO_1  = 2'b00,
    PSC_1_TO_4  = 2'b01,
    PSC_1_TO_16 = 2'b10,
    PSC_1_TO_16B = 2'b11
  } prescale_type;

  typedef logic [3:0] timer_id_type;

endpackage : pwm_pkg

// File: core/ccp_standard_pwm.sv
// Standard 10-bit PWM channel with its period timer and an Avalon-MM register slave.
`timescale 1ns/100ps
`include "pwm_consts.svh"
// Function
// - Drive pulse-width waveform, 10-bit duty resolution.
// - Pin driven only while direction bit clear.
// - Control register zero releases the pin.
// - Time base is timer count plus two bits.
// - Active duty copy read-only in PWM mode.
// - Timer select field only names permitted timer; one period timer serves all.
// - Period is limit plus one, times four, prescale.
// - Count at limit restarts at zero next increment.
// - Pin set at period start unless duty zero.
// - Buffered duty loads active copy at restart.
// - Postscaler has no effect on period.
// - Duty is low buffer plus two fraction bits.
// - Duty updates take effect after period match.
// - High time is duty times prescaled clock.
// - Low bits from quarter counter at 1:1.
// - Pin cleared when time base equals duty.
// - Active copy and fraction latch double buffer.
// - Duty beyond period leaves pin unchanged.
module ccp_standard_pwm
  import pwm_pkg::*;
#(
  parameter int CHANNEL = 1
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             pwm_output_pin,
  output logic             pwm_output_pin_oe
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (CHANNEL < 1 || CHANNEL > 10) begin : g_bad_channel
    $error("CHANNEL must lie between 1 and 10");
  end

  if (`OSC_PER_INSTR * `PSC_DIV_16 > 64) begin : g_bad_prescale
    $error("Prescaler counter is too narrow for the largest division");
  end

  // Maps the select field onto the timer number allowed for this channel.
  function automatic timer_id_type timer_of(input logic [1:0] sel);
    timer_id_type second;
    timer_id_type third;
    second = (CHANNEL <= 4) ? 4'd4 : (CHANNEL <= 7) ? 4'd6 : 4'd8;
    third  = (CHANNEL <= 4) ? 4'd6 : (CHANNEL <= 7) ? 4'd8 : 4'd10;
    case (sel)
      2'b00:   timer_of = 4'd2;
      2'b01:   timer_of = second;
      2'b10:   timer_of = third;
      default: timer_of = 4'd2;
    endcase
  endfunction : timer_of

  // Last prescaler value before a timer increment: oscillator periods per step minus one.
  function automatic logic [5:0] wrap_of(input prescale_type p);
    case (p)
      PSC_1_TO_1: wrap_of = 6'(`OSC_PER_INSTR * `PSC_DIV_1 - 1);
      PSC_1_TO_4: wrap_of = 6'(`OSC_PER_INSTR * `PSC_DIV_4 - 1);
      default:    wrap_of = 6'(`OSC_PER_INSTR * `PSC_DIV_16 - 1);
    endcase
  endfunction : wrap_of

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0]  channel_control_r;
  logic [7:0]  duty_low_buffer_r;
  logic [7:0]  duty_active_copy_r;
  logic [1:0]  frac_latch_r;
  logic [7:0]  period_limit_r;
  logic [7:0]  period_timer_control_r;
  logic [1:0]  timer_source_select_r;
  logic        pin_direction_bit_r;
  logic        timer_match_flag_r;
  logic [7:0]  period_timer_count_r;
  logic [5:0]  psc_r;
  logic        out_r;
  logic [31:0] readdata_r;
  logic        waitrequest_r;

  logic        pwm_mode;
  logic        ctrl_zero;
  logic        timer_run;
  logic        inc;
  logic        restart;
  logic        wr_fire;
  logic        take;
  logic        wr_lane0;
  logic [7:0]  wr_byte;
  logic [1:0]  low_bits;
  logic [9:0]  time_base;
  logic [9:0]  duty_active;
  logic [9:0]  duty_next;
  logic [31:0] rd_mux;
  prescale_type psc_sel;

  assign pwm_mode  = channel_control_r[`CTRL_MODE_MSB -: 2] == `PWM_MODE_CODE;
  assign ctrl_zero = channel_control_r == 8'h00;
  assign timer_run = period_timer_control_r[`TCTRL_RUN_BIT];
  assign psc_sel   = prescale_type'(period_timer_control_r[`TCTRL_PSC_MSB:`TCTRL_PSC_LSB]);
  // The postscaler field is stored for software only and never reaches the timer.
  assign inc       = timer_run && (psc_r == wrap_of(psc_sel));
  assign restart   = inc && (period_timer_count_r == period_limit_r);
  assign wr_fire   = avs_write && !waitrequest_r;
  assign wr_lane0  = wr_fire && avs_byteenable[0];
  assign wr_byte   = avs_writedata[7:0];
  // An access is taken on the edge at which it meets a raised waitrequest.
  assign take      = (avs_read || avs_write) && waitrequest_r;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // True when a completed write with lane 0 enabled targets the given offset.
  function automatic logic wr_hit(input logic [5:0] ofs);
    wr_hit = wr_lane0 && (avs_address == ofs);
  endfunction : wr_hit

  // ---------------------------------------------------------------------------
  // Time base and compare
  // ---------------------------------------------------------------------------
  // At 1:1 the quarter-cycle counter is the prescaler itself, so both sources share psc_r.
  always_comb begin
    case (psc_sel)
      PSC_1_TO_1: low_bits = psc_r[1:0];
      PSC_1_TO_4: low_bits = psc_r[3:2];
      default:    low_bits = psc_r[5:4];
    endcase
  end

  assign time_base   = {period_timer_count_r, low_bits};
  assign duty_active = {duty_active_copy_r, frac_latch_r};
  assign duty_next   = {duty_low_buffer_r, channel_control_r[`CTRL_FRAC_MSB:`CTRL_FRAC_LSB]};

  // ---------------------------------------------------------------------------
  // Prescaler and period timer
  // ---------------------------------------------------------------------------
  // A software load of the count also clears the prescaler, so the new count starts on a whole step.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      psc_r <= 6'h00;
    end else if (wr_hit(`OFS_PERIOD_TIMER_CNT)) begin
      psc_r <= 6'h00;
    end else if (inc) begin
      psc_r <= 6'h00;
    end else if (timer_run) begin
      psc_r <= psc_r + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_timer_count_r <= 8'h00;
    end else if (wr_hit(`OFS_PERIOD_TIMER_CNT)) begin
      period_timer_count_r <= wr_byte;
    end else if (restart) begin
      period_timer_count_r <= 8'h00;
    end else if (inc) begin
      period_timer_count_r <= period_timer_count_r + 8'h01;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_match_flag_r <= 1'b0;
    end else if (restart) begin
      timer_match_flag_r <= 1'b1;
    end else if (wr_hit(`OFS_INTERRUPT_REQUEST)) begin
      timer_match_flag_r <= wr_byte[0];
    end
  end

  // ---------------------------------------------------------------------------
  // Duty double buffer
  // ---------------------------------------------------------------------------
  // Outside PWM mode the active copy is a plain register; in PWM mode only the restart loads it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      duty_active_copy_r <= `RST_DUTY;
    end else if (pwm_mode && restart) begin
      duty_active_copy_r <= duty_next[9:2];
    end else if (!pwm_mode && wr_hit(`OFS_DUTY_ACTIVE_COPY)) begin
      duty_active_copy_r <= wr_byte;
    end
  end

  // The fraction latch takes no writes, so a half-written duty never reaches the compare.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      frac_latch_r <= 2'b00;
    end else if (pwm_mode && restart) begin
      frac_latch_r <= duty_next[1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Output waveform
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_r <= 1'b0;
    end else if (!pwm_mode) begin
      out_r <= 1'b0;
    end else if (restart) begin
      out_r <= duty_next != 10'h000;
    end else if (time_base == duty_active) begin
      // A duty beyond the period never matches, so the level simply holds.
      out_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  // The pin falls in the very cycle in which the time base reaches the duty, which makes the
  // high time exactly duty steps long; out_r only remembers that the match has passed.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_output_pin <= 1'b0;
    end else begin
      pwm_output_pin <= out_r && (time_base != duty_active);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_output_pin_oe <= 1'b0;
    end else begin
      pwm_output_pin_oe <= pwm_mode && !ctrl_zero && !pin_direction_bit_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  // Bits that have no storage read back as zero, except the timer number beside the select field and the pwm_mode bit of the status register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      channel_control_r <= `RST_CHANNEL_CONTROL;
    end else if (wr_hit(`OFS_CHANNEL_CONTROL)) begin
      channel_control_r <= {2'b00, wr_byte[5:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      duty_low_buffer_r <= `RST_DUTY;
    end else if (wr_hit(`OFS_DUTY_LOW_BUFFER)) begin
      duty_low_buffer_r <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_limit_r <= `RST_PERIOD_LIMIT;
    end else if (wr_hit(`OFS_PERIOD_LIMIT)) begin
      period_limit_r <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_timer_control_r <= `RST_TIMER_CTRL;
    end else if (wr_hit(`OFS_PERIOD_TIMER_CTRL)) begin
      period_timer_control_r <= {1'b0, wr_byte[6:0]};
    end
  end

  // The select only names a timer; one period timer serves every choice.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_source_select_r <= `RST_TIMER_SELECT;
    end else if (wr_hit(`OFS_TIMER_SELECT)) begin
      timer_source_select_r <= wr_byte[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_direction_bit_r <= `RST_PIN_DIRECTION;
    end else if (wr_hit(`OFS_PIN_DIRECTION)) begin
      pin_direction_bit_r <= wr_byte[0];
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the access completes
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `OFS_CHANNEL_CONTROL:   rd_mux[7:0] = channel_control_r;
      `OFS_DUTY_LOW_BUFFER:   rd_mux[7:0] = duty_low_buffer_r;
      `OFS_DUTY_ACTIVE_COPY:  rd_mux[7:0] = duty_active_copy_r;
      `OFS_PERIOD_LIMIT:      rd_mux[7:0] = period_limit_r;
      `OFS_PERIOD_TIMER_CTRL: rd_mux[7:0] = period_timer_control_r;
      `OFS_TIMER_SELECT:      rd_mux[7:0] = {2'b00, timer_of(timer_source_select_r), timer_source_select_r};
      `OFS_PIN_DIRECTION:     rd_mux[0]   = pin_direction_bit_r;
      `OFS_INTERRUPT_REQUEST: rd_mux[0]   = timer_match_flag_r;
      `OFS_PERIOD_TIMER_CNT:  rd_mux[7:0] = period_timer_count_r;
      `OFS_CHANNEL_STATUS:    rd_mux[3:0] = {frac_latch_r, pwm_mode, out_r};
      default:                rd_mux      = 32'h0000_0000;
    endcase
  end

  // Waitrequest idles high and drops for one cycle, so every access costs exactly two cycles.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waitrequest_r <= 1'b1;
    end else if (take) begin
      waitrequest_r <= 1'b0;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  // Read data is captured at the take edge and stands through the answer cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      readdata_r <= 32'h0000_0000;
    end else if (take) begin
      readdata_r <= avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata    = readdata_r;

endmodule : ccp_standard_pwm

// File: tb/pwm_checker_asserts.sv
// Concurrent checks on the bus handshake and pin outputs of the PWM channel.
`timescale 1ns/100ps
module pwm_checker (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pwm_output_pin,
  input wire logic        pwm_output_pin_oe
);
  logic       dir_r;
  logic [5:0] ctrl_r;
  logic       wr_done;
  // Shadows follow completed writes only, so they change on the same edge as the registers.
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dir_r <= 1'b1;
    end else if (wr_done && avs_address == 6'h18) begin
      dir_r <= avs_writedata[0];
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 6'h00;
    end else if (wr_done && avs_address == 6'h00) begin
      ctrl_r <= avs_writedata[5:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("waitrequest low too long");
  read_hold_a: assert property (avs_waitrequest && !(avs_read || avs_write) |=> $stable(avs_readdata))
    else $error("readdata changed while idle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 6'h24 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  dir_off_a: assert property (dir_r |=> !pwm_output_pin_oe) else $error("pin driven with direction set");
  ctrl_off_a: assert property (ctrl_r == 6'h00 |=> !pwm_output_pin_oe) else $error("pin held by zero control");
  oe_mode_a: assert property (pwm_output_pin_oe |-> $past(ctrl_r[3:2]) == 2'b11) else $error("pin driven outside mode");
  pin_quiet_a: assert property ((ctrl_r[3:2] != 2'b11) [*2] |=> !pwm_output_pin) else $error("pin high outside mode");
endmodule : pwm_checker
bind ccp_standard_pwm pwm_checker u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe(pwm_output_pin_oe)
);

// File: tb/pwm_load.sv
// Load on the PWM pin: resolves the line and measures each high time and period in clocks.
`timescale 1ns/100ps
module pwm_load (
  input  wire logic clk_sys,
  input  wire logic pin,
  input  wire logic oe,
  output logic      line,
  output logic      meas_v,
  output int        hi_cnt,
  output int        per_cnt
);
  int   hi = 0;
  int   per = 0;
  logic prev = 1'b0;
  logic seen = 1'b0;
  // An undriven line is pulled down, so a released pin never shows a stale level.
  assign line = oe ? pin : 1'b0;
  always @(posedge clk_sys) begin
    meas_v <= 1'b0;
    prev <= line;
    if (line && !prev) begin
      meas_v <= seen;
      hi_cnt <= hi;
      per_cnt <= per;
      hi <= 1;
      per <= 1;
      seen <= 1'b1;
    end else begin
      hi <= hi + int'(line);
      per <= per + 1;
    end
  end
endmodule : pwm_load

// File: tb/tb_top.sv
// Self-checking bench for the standard PWM channel with a load on its pin.
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys;
  logic        rstn;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [3:0]  be_sel = 4'hF;
  logic        avs_waitrequest;
  logic        pin;
  logic        oe;
  logic        line;
  logic        meas_v;
  int          hi_cnt;
  int          per_cnt;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          per_e;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  ccp_standard_pwm #(.CHANNEL(1)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pwm_output_pin(pin), .pwm_output_pin_oe(oe));
  pwm_load u_load (.clk_sys(clk_sys), .pin(pin), .oe(oe), .line(line), .meas_v(meas_v), .hi_cnt(hi_cnt),
    .per_cnt(per_cnt));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= 32'(d);
    avs_byteenable <= be_sel;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    rq.push_back(32'(e));
    bus(1'b0, a, 8'h00);
  endtask : rd
  // The first two reports may cover a partial period, so only the third is judged.
  task automatic measure(input int hi);
    repeat (2) @(posedge clk_sys iff meas_v === 1'b1);
    @(posedge clk_sys);
    mq.push_back(32'(per_e));
    mq.push_back(32'(hi));
    @(posedge clk_sys iff meas_v === 1'b1);
    @(posedge clk_sys);
  endtask : measure
  task automatic lvl(input logic v);
    logic ok;
    ok = 1'b1;
    repeat (2 * per_e) @(posedge clk_sys);
    repeat (per_e) begin
      @(posedge clk_sys);
      if (line !== v || oe !== 1'b1) ok = 1'b0;
    end
    chk(32'(ok), 32'h1);
  endtask : lvl
  task automatic run_pwm(input logic [1:0] psc, input int p);
    int pr;
    logic [9:0] duty;
    pr = 8 + $urandom % 24;
    duty = 10'(1 + $urandom % (4 * pr + 3));
    per_e = (pr + 1) * 4 * p;
    bus(1'b1, 6'h18, 8'h01);
    bus(1'b1, 6'h0C, 8'(pr));
    bus(1'b1, 6'h00, {2'b00, duty[1:0], 4'hC});
    bus(1'b1, 6'h04, duty[9:2]);
    bus(1'b1, 6'h14, 8'h00);
    bus(1'b1, 6'h1C, 8'h00);
    bus(1'b1, 6'h20, 8'h00);
    bus(1'b1, 6'h10, {1'b0, 4'($urandom), 1'b1, psc});
    bus(1'b1, 6'h18, 8'h00);
    measure(int'(duty) * p);
    chk(32'(oe), 32'h1);
    rd(6'h08, duty[9:2]);
    bus(1'b1, 6'h08, ~duty[9:2]);
    rd(6'h08, duty[9:2]);
  endtask : run_pwm
  task automatic stop_test();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0) chk(avs_readdata, rq.pop_front());
    if (meas_v === 1'b1 && mq.size() > 1) begin
      chk(32'(per_cnt), mq.pop_front());
      chk(32'(hi_cnt), mq.pop_front());
    end
  end
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(32'hdeaf_240e));
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(6'h0C, 8'hFF);
    rd(6'h18, 8'h01);
    rd(6'h3C, 8'h00);
    be_sel = 4'hE;
    bus(1'b1, 6'h0C, 8'h55);
    be_sel = 4'hF;
    rd(6'h0C, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 6'h14, 8'(i));
      rd(6'h14, 8'({4'(2 + 2 * i), 2'(i)}));
    end
    run_pwm(2'b00, 1);
    run_pwm(2'b01, 4);
    run_pwm(2'b10, 16);
    run_pwm(2'b11, 16);
    bus(1'b1, 6'h04, 8'h00);
    bus(1'b1, 6'h00, 8'h0C);
    lvl(1'b0);
    bus(1'b1, 6'h04, 8'hFF);
    bus(1'b1, 6'h00, 8'h3C);
    lvl(1'b1);
    bus(1'b1, 6'h18, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk(32'(oe), 32'h0);
    bus(1'b1, 6'h18, 8'h00);
    bus(1'b1, 6'h00, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(32'(oe), 32'h0);
    stop_test();
  end
endmodule : tb_top
